// *** shared/boot_loader_consts.vh ***
`ifndef BOOT_LOADER_CONSTS_VH
`define BOOT_LOADER_CONSTS_VH

// Decoded boot modes
`define MODE_EPROM        3'h0
`define MODE_HOST         3'h1
`define MODE_LINK         3'h2
`define MODE_SPI          3'h3
`define MODE_NONE         3'h4

// Sequencer states
`define ST_SAMPLE         3'h0
`define ST_LOAD           3'h1
`define ST_DRAIN          3'h2
`define ST_DONE           3'h3
`define ST_NOBOOT         3'h4

// Transfer counts and start addresses
`define INSTR_COUNT_INIT  9'h100
`define EXT_COUNT_INIT    11'h600
`define EPROM_ADDR_INIT   24'h800000
`define MEM_ADDR_INIT     20'h40000
`define DONE_VECTOR       20'h40050

// EPROM access: seven wait states, eight cycles in total
`define EPROM_WAIT_LAST   3'h7

// Units packed into one 48-bit instruction
`define UNITS_NIBBLE      4'hC
`define UNITS_BYTE        4'h6
`define UNITS_HALF        4'h3

// DMA channel of each mode
`define DMA_CH_EXT        4'hA
`define DMA_CH_SPI        4'h8
`define DMA_CH_LINK       4'h4

// Layout of the asynchronous input bundle
`define SYNC_WIDTH        53
`define SY_EPROM_STRAP    0
`define SY_LINK_STRAP     1
`define SY_BMS_IN         2
`define SY_HOST_WIDE      3
`define SY_BUS_OWNER      4
`define SY_BUS_TRISTATE   5
`define SY_EPROM_LO       6
`define SY_EPROM_HI       13
`define SY_HOST_LO        14
`define SY_HOST_HI        29
`define SY_HOST_VALID     30
`define SY_LINK_LO        31
`define SY_LINK_HI        34
`define SY_LINK_VALID     35
`define SY_SPI_LO         36
`define SY_SPI_HI         51
`define SY_SPI_VALID      52

`endif

// *** src/word_buffer2.v ***
`timescale 1ns/1ns
`default_nettype none

module word_buffer2 #(
    parameter W = 68
) (
    // Clock and control
    input  wire         clk,
    input  wire         rst_b,
    input  wire         ce,
    // Filling side
    input  wire         in_valid,
    output reg          in_ready,
    input  wire [W-1:0] in_data,
    // Draining side
    output reg          out_valid,
    input  wire         out_ready,
    output reg  [W-1:0] out_data
);

    reg [W-1:0] slot1_reg;
    reg [1:0]   count_reg;
    reg [1:0]   count_next;
    wire        push;
    wire        pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    always @* begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // Ready and valid are registered so both sides see flip-flop outputs
    always @(posedge clk) begin
        if (!rst_b) begin
            count_reg <= 2'h0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
            slot1_reg <= {W{1'b0}};
        end else if (ce) begin
            count_reg <= count_next;
            in_ready  <= (count_next != 2'h2);
            out_valid <= (count_next != 2'h0);
            if (pop) begin
                out_data <= (count_reg == 2'h2) ? slot1_reg : in_data;
                if (push && count_reg == 2'h2) begin
                    slot1_reg <= in_data;
                end
            end else if (push) begin
                if (count_reg == 2'h0) begin
                    out_data <= in_data;
                end else begin
                    slot1_reg <= in_data;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** src/boot_mode_select_loader.v ***
// Overview of operation
// - EPROM strap high, link strap low: boot from 8-bit EPROM on external port.
// - EPROM strap low: link strap and boot memory select pick the mode.
// - Both straps low, select high: host boot with 8- or 16-bit host data.
// - Link strap high, select high: link boot, 4-bit data into link buffer 4.
// - Link strap high, select low: SPI boot from receive buffer on channel 8.
// - Both straps low, select low: no boot load, execute from external memory.
// - Select pin is EPROM chip select output in EPROM mode, else input.
// - The driven select output can be placed in high impedance.
// - In ST_LOAD, only the current bus owner drives the select output; it is released three cycles after ownership is lost.
// - After reset the mode's DMA channel loads 256 kernel instructions.
// - Each EPROM read is asynchronous with seven wait states, eight cycles.
// - EPROM address starts at 0x800000 and increments after each byte.
// - At zero counts: stop, raise done interrupt, release select, vector 0x40050.
`timescale 1ns/1ns
`default_nettype none
`include "boot_loader_consts.vh"

module boot_mode_select_loader (
    // Clock, reset, enable
    input  wire        CLK_SYS,
    input  wire        RST_B,
    input  wire        CE,
    // Boot straps and select pin
    input  wire        EPROM_BOOT_STRAP,
    input  wire        LINK_BOOT_STRAP,
    input  wire        BOOT_MEMORY_SELECT_IN,
    output reg         BOOT_MEMORY_SELECT_OUT,
    output reg         BOOT_MEMORY_SELECT_OE_B,
    // Bus arbitration
    input  wire        BUS_OWNER,
    input  wire        BUS_TRISTATE,
    // EPROM external port
    output reg  [23:0] EPROM_ADDR,
    output reg         EPROM_RD_B,
    input  wire [7:0]  EPROM_DATA,
    // Host port
    input  wire        HOST_WIDE,
    input  wire [15:0] HOST_DATA,
    input  wire        HOST_VALID,
    output reg         HOST_READY,
    // Link port
    input  wire [3:0]  LINK_DATA,
    input  wire        LINK_VALID,
    output reg         LINK_READY,
    // Serial receive buffer
    input  wire [15:0] SERIAL_RECEIVE_BUFFER,
    input  wire        SERIAL_VALID,
    output reg         SERIAL_READY,
    // Internal memory write
    output wire [19:0] MEM_ADDR,
    output wire [47:0] MEM_DATA,
    output wire        MEM_VALID,
    input  wire        MEM_READY,
    // Status
    output reg  [2:0]  BOOT_MODE,
    output reg  [3:0]  BOOT_DMA_CHANNEL,
    output reg         BOOT_DMA_DONE_INTERRUPT,
    output reg         VECTOR_VALID,
    output reg  [19:0] VECTOR_ADDR,
    output reg         EXT_EXECUTE
);

    wire [`SYNC_WIDTH-1:0] async_in;
    reg  [`SYNC_WIDTH-1:0] sync1_reg;
    reg  [`SYNC_WIDTH-1:0] sync2_reg;

    reg  [2:0]  state_reg;
    reg  [2:0]  mode_reg;
    reg         host_wide_reg;
    reg  [8:0]  instr_count_reg;
    reg  [10:0] ext_count_reg;
    reg  [19:0] mem_addr_reg;
    reg  [47:0] pack_reg;
    reg  [3:0]  unit_count_reg;
    reg         word_pend_reg;
    reg         rd_active_reg;
    reg  [2:0]  wait_reg;
    reg         valid_prev_reg;

    reg  [2:0]  mode_next;
    reg  [15:0] unit_data;
    reg  [3:0]  units_last;
    reg  [47:0] pack_next;
    reg         stream_valid;
    wire        unit_take;
    wire        eprom_take;
    wire        stream_take;
    wire        word_push;
    wire        buf_in_ready;
    wire        load_done;
    wire        select_drive;

    assign async_in = {
        SERIAL_VALID, SERIAL_RECEIVE_BUFFER, LINK_VALID, LINK_DATA,
        HOST_VALID, HOST_DATA, EPROM_DATA, BUS_TRISTATE, BUS_OWNER,
        HOST_WIDE, BOOT_MEMORY_SELECT_IN, LINK_BOOT_STRAP, EPROM_BOOT_STRAP
    };

    // Pins pass two flip-flops; left free of reset so they settle during it
    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_WIDTH; gi = gi + 1) begin : g_sync
            always @(posedge CLK_SYS) begin
                if (CE) begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    always @* begin
        if (sync2_reg[`SY_EPROM_STRAP]) begin
            mode_next = `MODE_EPROM;
        end else if (sync2_reg[`SY_LINK_STRAP]) begin
            mode_next = sync2_reg[`SY_BMS_IN] ? `MODE_LINK : `MODE_SPI;
        end else begin
            mode_next = sync2_reg[`SY_BMS_IN] ? `MODE_HOST : `MODE_NONE;
        end
    end

    // Unit source and packing width per mode
    always @* begin
        unit_data    = 16'h0000;
        units_last   = `UNITS_BYTE - 4'h1;
        stream_valid = 1'b0;
        case (mode_reg)
            `MODE_EPROM: begin
                unit_data = {8'h00, sync2_reg[`SY_EPROM_HI:`SY_EPROM_LO]};
            end
            `MODE_HOST: begin
                unit_data    = sync2_reg[`SY_HOST_HI:`SY_HOST_LO];
                stream_valid = sync2_reg[`SY_HOST_VALID];
                if (host_wide_reg) begin
                    units_last = `UNITS_HALF - 4'h1;
                end
            end
            `MODE_LINK: begin
                unit_data    = {12'h000, sync2_reg[`SY_LINK_HI:`SY_LINK_LO]};
                stream_valid = sync2_reg[`SY_LINK_VALID];
                units_last   = `UNITS_NIBBLE - 4'h1;
            end
            `MODE_SPI: begin
                unit_data    = sync2_reg[`SY_SPI_HI:`SY_SPI_LO];
                stream_valid = sync2_reg[`SY_SPI_VALID];
                units_last   = `UNITS_HALF - 4'h1;
            end
            default: begin
                unit_data = 16'h0000;
            end
        endcase
    end

    // Least significant unit first: new units enter at the top
    always @* begin
        pack_next = pack_reg;
        if (units_last == `UNITS_NIBBLE - 4'h1) begin
            pack_next = {unit_data[3:0], pack_reg[47:4]};
        end else if (units_last == `UNITS_HALF - 4'h1) begin
            pack_next = {unit_data, pack_reg[47:16]};
        end else begin
            pack_next = {unit_data[7:0], pack_reg[47:8]};
        end
    end

    // byte taken at end of eighth cycle
    assign eprom_take  = (mode_reg == `MODE_EPROM) && rd_active_reg &&
                         (wait_reg == `EPROM_WAIT_LAST);
    assign stream_take = (mode_reg != `MODE_EPROM) && stream_valid && !valid_prev_reg &&
                         !word_pend_reg && (state_reg == `ST_LOAD);
    assign unit_take   = eprom_take || stream_take;
    assign word_push   = word_pend_reg && buf_in_ready;
    assign load_done   = (instr_count_reg == 9'h000) &&
                         ((mode_reg != `MODE_EPROM) || (ext_count_reg == 11'h000));
    // owner only, and never while told to float
    assign select_drive = sync2_reg[`SY_BUS_OWNER] && !sync2_reg[`SY_BUS_TRISTATE];

    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state_reg               <= `ST_SAMPLE;
            mode_reg                <= `MODE_NONE;
            host_wide_reg           <= 1'b0;
            instr_count_reg         <= 9'h000;
            ext_count_reg           <= 11'h000;
            mem_addr_reg            <= `MEM_ADDR_INIT;
            pack_reg                <= 48'h000000000000;
            unit_count_reg          <= 4'h0;
            word_pend_reg           <= 1'b0;
            rd_active_reg           <= 1'b0;
            wait_reg                <= 3'h0;
            valid_prev_reg          <= 1'b0;
            EPROM_ADDR              <= `EPROM_ADDR_INIT;
            EPROM_RD_B              <= 1'b1;
            BOOT_MEMORY_SELECT_OUT  <= 1'b1;
            BOOT_MEMORY_SELECT_OE_B <= 1'b1;
            HOST_READY              <= 1'b0;
            LINK_READY              <= 1'b0;
            SERIAL_READY            <= 1'b0;
            BOOT_MODE               <= `MODE_NONE;
            BOOT_DMA_CHANNEL        <= 4'h0;
            BOOT_DMA_DONE_INTERRUPT <= 1'b0;
            VECTOR_VALID            <= 1'b0;
            VECTOR_ADDR             <= 20'h00000;
            EXT_EXECUTE             <= 1'b0;
        end else if (CE) begin
            valid_prev_reg          <= stream_valid;
            BOOT_DMA_DONE_INTERRUPT <= 1'b0;
            case (state_reg)
                `ST_SAMPLE: begin
                    mode_reg      <= mode_next;
                    BOOT_MODE     <= mode_next;
                    host_wide_reg <= sync2_reg[`SY_HOST_WIDE];
                    // channel set up for 256 instructions
                    instr_count_reg <= `INSTR_COUNT_INIT;
                    ext_count_reg   <= `EXT_COUNT_INIT;
                    mem_addr_reg    <= `MEM_ADDR_INIT;
                    case (mode_next)
                        `MODE_SPI: begin
                            BOOT_DMA_CHANNEL <= `DMA_CH_SPI;
                        end
                        `MODE_LINK: begin
                            BOOT_DMA_CHANNEL <= `DMA_CH_LINK;
                        end
                        `MODE_NONE: begin
                            BOOT_DMA_CHANNEL <= 4'h0;
                        end
                        default: begin
                            BOOT_DMA_CHANNEL <= `DMA_CH_EXT;
                        end
                    endcase
                    if (mode_next == `MODE_NONE) begin
                        state_reg <= `ST_NOBOOT;
                    end else begin
                        state_reg <= `ST_LOAD;
                    end
                end
                `ST_LOAD: begin
                    if (mode_reg == `MODE_EPROM) begin
                        BOOT_MEMORY_SELECT_OUT  <= 1'b0;
                        BOOT_MEMORY_SELECT_OE_B <= !select_drive;
                        if (!rd_active_reg && !word_pend_reg &&
                            ext_count_reg != 11'h000 && select_drive) begin
                            rd_active_reg <= 1'b1;
                            wait_reg      <= 3'h0;
                            EPROM_RD_B    <= 1'b0;
                        end else if (rd_active_reg) begin
                            wait_reg <= wait_reg + 3'h1;
                            if (eprom_take) begin
                                rd_active_reg <= 1'b0;
                                EPROM_RD_B    <= 1'b1;
                                EPROM_ADDR    <= EPROM_ADDR + 24'h000001;
                                ext_count_reg <= ext_count_reg - 11'h001;
                            end
                        end
                    end
                    // Ready drops while a word waits, so a stalled buffer backs up the source
                    HOST_READY   <= (mode_reg == `MODE_HOST) && !word_pend_reg && !unit_take;
                    LINK_READY   <= (mode_reg == `MODE_LINK) && !word_pend_reg && !unit_take;
                    SERIAL_READY <= (mode_reg == `MODE_SPI) && !word_pend_reg && !unit_take;
                    if (unit_take) begin
                        pack_reg <= pack_next;
                        if (unit_count_reg == units_last) begin
                            unit_count_reg <= 4'h0;
                            word_pend_reg  <= 1'b1;
                        end else begin
                            unit_count_reg <= unit_count_reg + 4'h1;
                        end
                    end
                    if (word_push) begin
                        word_pend_reg   <= 1'b0;
                        instr_count_reg <= instr_count_reg - 9'h001;
                        mem_addr_reg    <= mem_addr_reg + 20'h00001;
                    end
                    if (load_done && !word_pend_reg) begin
                        HOST_READY   <= 1'b0;
                        LINK_READY   <= 1'b0;
                        SERIAL_READY <= 1'b0;
                        state_reg    <= `ST_DRAIN;
                    end
                end
                `ST_DRAIN: begin
                    // Completion waits until the last word has left the buffer
                    if (!MEM_VALID) begin
                        state_reg <= `ST_DONE;
                        BOOT_DMA_DONE_INTERRUPT <= 1'b1;
                        BOOT_MEMORY_SELECT_OUT  <= 1'b1;
                        BOOT_MEMORY_SELECT_OE_B <= 1'b1;
                        VECTOR_VALID            <= 1'b1;
                        VECTOR_ADDR             <= `DONE_VECTOR;
                    end
                end
                `ST_DONE: begin
                    state_reg <= `ST_DONE;
                end
                `ST_NOBOOT: begin
                    EXT_EXECUTE <= 1'b1;
                end
                default: begin
                    state_reg <= `ST_SAMPLE;
                end
            endcase
        end
    end

    // Two-entry buffer decouples packer from memory stalls
    word_buffer2 #(
        .W(68)
    ) u_buffer (
        .clk       (CLK_SYS),
        .rst_b     (RST_B),
        .ce        (CE),
        .in_valid  (word_pend_reg),
        .in_ready  (buf_in_ready),
        .in_data   ({mem_addr_reg, pack_reg}),
        .out_valid (MEM_VALID),
        .out_ready (MEM_READY),
        .out_data  ({MEM_ADDR, MEM_DATA})
    );

endmodule

`default_nettype wire

// *** testbench/boot_loader_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "boot_loader_consts.vh"

module boot_loader_properties (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_B,
    // Select pin and bus
    input wire logic        BUS_OWNER,
    input wire logic        BUS_TRISTATE,
    input wire logic        BOOT_MEMORY_SELECT_OUT,
    input wire logic        BOOT_MEMORY_SELECT_OE_B,
    // EPROM port
    input wire logic [23:0] EPROM_ADDR,
    input wire logic        EPROM_RD_B,
    // Memory side
    input wire logic [19:0] MEM_ADDR,
    input wire logic [47:0] MEM_DATA,
    input wire logic        MEM_VALID,
    input wire logic        MEM_READY,
    // Status
    input wire logic [2:0]  BOOT_MODE,
    input wire logic [3:0]  BOOT_DMA_CHANNEL,
    input wire logic        BOOT_DMA_DONE_INTERRUPT,
    input wire logic        VECTOR_VALID,
    input wire logic [19:0] VECTOR_ADDR,
    input wire logic        EXT_EXECUTE
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    sequence read_pulse_s;
        !EPROM_RD_B [*8] ##1 EPROM_RD_B;
    endsequence
    sequence stop_s;
        !MEM_VALID && EPROM_RD_B;
    endsequence
    sequence wake_s;
        !BOOT_DMA_DONE_INTERRUPT && VECTOR_VALID && VECTOR_ADDR == `DONE_VECTOR
            && BOOT_MEMORY_SELECT_OE_B && BOOT_MEMORY_SELECT_OUT;
    endsequence

    read_length_a: assert property ($fell(EPROM_RD_B) |-> read_pulse_s)
        else $error("EPROM read strobe not low for eight cycles");
    read_select_a: assert property (!EPROM_RD_B |-> !BOOT_MEMORY_SELECT_OE_B
        && !BOOT_MEMORY_SELECT_OUT) else $error("EPROM read without chip select");
    addr_step_a: assert property ($rose(EPROM_RD_B) |-> EPROM_ADDR == $past(EPROM_ADDR) + 24'h1)
        else $error("EPROM address did not step by one");
    addr_range_a: assert property (!EPROM_RD_B |-> EPROM_ADDR >= `EPROM_ADDR_INIT
        && EPROM_ADDR <= 24'h8005FF) else $error("EPROM address outside boot image");
    // Two-flop sync plus one register on the bus inputs
    owner_only_a: assert property (!BUS_OWNER [*4] |-> BOOT_MEMORY_SELECT_OE_B)
        else $error("select driven without bus ownership");
    float_release_a: assert property (BUS_TRISTATE [*4] |-> BOOT_MEMORY_SELECT_OE_B)
        else $error("select driven while floating requested");
    mode_held_a: assert property ($past(RST_B) && $past(RST_B, 2) |-> $stable(BOOT_MODE))
        else $error("boot mode changed after sampling");
    channel_map_a: assert property (BOOT_DMA_CHANNEL == (BOOT_MODE == `MODE_SPI ? `DMA_CH_SPI :
        BOOT_MODE == `MODE_LINK ? `DMA_CH_LINK : BOOT_MODE == `MODE_NONE ? 4'h0 : `DMA_CH_EXT))
        else $error("channel does not match boot mode");
    done_wakeup_a: assert property ($rose(BOOT_DMA_DONE_INTERRUPT) |-> stop_s ##1 wake_s)
        else $error("wake-up sequence wrong");
    noboot_idle_a: assert property (EXT_EXECUTE |-> BOOT_MODE == `MODE_NONE && !MEM_VALID
        && EPROM_RD_B && !BOOT_DMA_DONE_INTERRUPT) else $error("activity in no-boot mode");
    mem_hold_a: assert property (MEM_VALID && !MEM_READY |=> MEM_VALID
        && $stable(MEM_DATA) && $stable(MEM_ADDR)) else $error("stalled word not held");
endmodule

bind boot_mode_select_loader boot_loader_properties props (.CLK_SYS, .RST_B, .BUS_OWNER,
    .BUS_TRISTATE, .BOOT_MEMORY_SELECT_OUT, .BOOT_MEMORY_SELECT_OE_B, .EPROM_ADDR, .EPROM_RD_B,
    .MEM_ADDR, .MEM_DATA, .MEM_VALID, .MEM_READY, .BOOT_MODE, .BOOT_DMA_CHANNEL,
    .BOOT_DMA_DONE_INTERRUPT, .VECTOR_VALID, .VECTOR_ADDR, .EXT_EXECUTE);
`default_nettype wire

// *** testbench/boot_eprom_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module boot_eprom_model (
    // Bus side
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [23:0] addr,
    input  wire logic        rd_b,
    input  wire logic        cs_b,
    output var  logic [7:0]  data
);
    logic [2:0]  age;
    logic [23:0] off;

    assign off = addr - 24'h800000;
    initial data = 8'hA5;

    always @(posedge clk) begin
        if (rd_b || cs_b) begin
            age <= 3'h0;
        end else if (age != 3'h7) begin
            age <= age + 3'h1;
        end
    end

    // byte only while selected
    // Idle bus keeps toggling so a stale byte is never mistaken for data
    always @(posedge clk) begin
        if (!rd_b && !cs_b && (!slow || age >= 3'h2)) begin
            data <= #1 8'(off * 24'h7 + 24'h3);
        end else begin
            data <= #1 ~data;
        end
    end
endmodule
`default_nettype wire

// *** testbench/boot_mode_select_loader_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "boot_loader_consts.vh"

module boot_mode_select_loader_test;
    logic        CLK_SYS, RST_B, CE, EPROM_BOOT_STRAP, LINK_BOOT_STRAP, BUS_OWNER;
    logic        BUS_TRISTATE, HOST_WIDE, MEM_READY, unit_v, bms_drv;
    logic [15:0] unit_d;
    logic [9:0]  cyc = 10'h000;
    int          n_fail, checked, n_words, ubits;
    wire         BOOT_MEMORY_SELECT_IN, BOOT_MEMORY_SELECT_OUT, BOOT_MEMORY_SELECT_OE_B;
    wire         EPROM_RD_B, HOST_READY, LINK_READY, SERIAL_READY, MEM_VALID, rdy;
    wire         BOOT_DMA_DONE_INTERRUPT, VECTOR_VALID, EXT_EXECUTE;
    wire [23:0]  EPROM_ADDR;
    wire [7:0]   EPROM_DATA;
    wire [19:0]  MEM_ADDR, VECTOR_ADDR;
    wire [47:0]  MEM_DATA;
    wire [2:0]   BOOT_MODE;
    wire [3:0]   BOOT_DMA_CHANNEL;

    // Pin follows bms_drv when the loader does not drive it
    assign BOOT_MEMORY_SELECT_IN = BOOT_MEMORY_SELECT_OE_B ? bms_drv : BOOT_MEMORY_SELECT_OUT;
    assign rdy = BOOT_MODE == `MODE_HOST ? HOST_READY :
                 BOOT_MODE == `MODE_LINK ? LINK_READY : SERIAL_READY;

    boot_mode_select_loader uut (.CLK_SYS, .RST_B, .CE, .EPROM_BOOT_STRAP, .LINK_BOOT_STRAP,
        .BOOT_MEMORY_SELECT_IN, .BOOT_MEMORY_SELECT_OUT, .BOOT_MEMORY_SELECT_OE_B, .BUS_OWNER,
        .BUS_TRISTATE, .EPROM_ADDR, .EPROM_RD_B, .EPROM_DATA, .HOST_WIDE, .HOST_DATA(unit_d),
        .HOST_VALID(unit_v), .HOST_READY, .LINK_DATA(unit_d[3:0]), .LINK_VALID(unit_v),
        .LINK_READY, .SERIAL_RECEIVE_BUFFER(unit_d), .SERIAL_VALID(unit_v), .SERIAL_READY,
        .MEM_ADDR, .MEM_DATA, .MEM_VALID, .MEM_READY, .BOOT_MODE, .BOOT_DMA_CHANNEL,
        .BOOT_DMA_DONE_INTERRUPT, .VECTOR_VALID, .VECTOR_ADDR, .EXT_EXECUTE);

    boot_eprom_model eprom (.clk(CLK_SYS), .slow(cyc[8]), .addr(EPROM_ADDR), .rd_b(EPROM_RD_B),
        .cs_b(BOOT_MEMORY_SELECT_IN), .data(EPROM_DATA));

    initial begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Units go LSB first, so unit j of the stream sits at slot j mod n
    function automatic logic [47:0] exp_word(input int k);
        logic [47:0] w;
        int          n;
        w = 48'h0;
        n = 48 / ubits;
        for (int i = 0; i < n; i++) begin
            w = w | ((48'(k * n + i) * 48'h7 + 48'h3) & ((48'h1 << ubits) - 48'h1)) << (i * ubits);
        end
        return w;
    endfunction

    // Memory side stalls one eighth of the time, long enough to fill the buffer
    always @(posedge CLK_SYS) begin
        if (RST_B && MEM_VALID && MEM_READY) begin
            check(48'(MEM_ADDR), 48'(`MEM_ADDR_INIT) + 48'(n_words));
            check(MEM_DATA, exp_word(n_words));
            n_words <= n_words + 1;
        end
        MEM_READY <= #1 (cyc[9:7] != 3'h7);
        cyc <= cyc + 10'h001;
    end

    task automatic boot(input logic e, l, s, w, input int bits, input logic [2:0] mode,
                        input logic [3:0] ch);
        RST_B = 1'b0;
        EPROM_BOOT_STRAP = e;
        LINK_BOOT_STRAP = l;
        bms_drv = s;
        HOST_WIDE = w;
        ubits = bits;
        n_words = 0;
        tick(16);
        RST_B = 1'b1;
        tick(3);
        check(48'(BOOT_MODE), 48'(mode));
        check(48'(BOOT_DMA_CHANNEL), 48'(ch));
        // Pins move after sampling; the mode must not follow
        EPROM_BOOT_STRAP = ~e;
        LINK_BOOT_STRAP = ~l;
        bms_drv = e | ~s;
    endtask

    task automatic finish_boot(input logic [2:0] mode);
        int k;
        k = 0;
        while (BOOT_DMA_DONE_INTERRUPT !== 1'b1 && k < 30000) begin
            tick(1);
            k++;
        end
        tick(1);
        check(48'(n_words), 48'h100);
        check(48'({VECTOR_VALID, BOOT_MEMORY_SELECT_OE_B, BOOT_DMA_DONE_INTERRUPT}), 48'h6);
        check(48'(VECTOR_ADDR), 48'(`DONE_VECTOR));
        check(48'(BOOT_MODE), 48'(mode));
    endtask

    task automatic wait_for(input logic lvl);
        int k;
        k = 0;
        while (rdy !== lvl && k < 400) begin
            tick(1);
            k++;
        end
        if (k == 400) check(48'(rdy), 48'(lvl));
    endtask

    // Each bus condition is tried alone, so neither check passes on the other's account
    task automatic eprom_boot();
        BUS_OWNER = 1'b1;
        BUS_TRISTATE = 1'b1;
        boot(1'b1, 1'b0, 1'b1, 1'b0, 8, `MODE_EPROM, `DMA_CH_EXT);
        tick(20);
        check(48'({BOOT_MEMORY_SELECT_OE_B, EPROM_RD_B}), 48'h3);
        BUS_OWNER = 1'b0;
        BUS_TRISTATE = 1'b0;
        tick(20);
        check(48'({BOOT_MEMORY_SELECT_OE_B, EPROM_RD_B}), 48'h3);
        BUS_OWNER = 1'b1;
        tick(6);
        check(48'({BOOT_MEMORY_SELECT_OE_B, BOOT_MEMORY_SELECT_OUT}), 48'h0);
        check(48'(EPROM_ADDR), 48'(`EPROM_ADDR_INIT));
        finish_boot(`MODE_EPROM);
    endtask

    // Every unit waits for ready, then holds until ready drops
    task automatic stream_boot(input logic l, s, w, input int bits, input logic [2:0] mode,
                               input logic [3:0] ch);
        boot(1'b0, l, s, w, bits, mode, ch);
        for (int j = 0; j < 256 * (48 / bits); j++) begin
            wait_for(1'b1);
            unit_d = 16'(j * 7 + 3);
            unit_v = 1'b1;
            wait_for(1'b0);
            unit_v = 1'b0;
            unit_d = ~unit_d;
            tick(2);
        end
        finish_boot(mode);
    endtask

    task automatic no_boot();
        boot(1'b0, 1'b0, 1'b0, 1'b0, 8, `MODE_NONE, 4'h0);
        tick(200);
        check(48'({EXT_EXECUTE, BOOT_DMA_DONE_INTERRUPT, VECTOR_VALID}), 48'h4);
        check(48'(n_words), 48'h0);
    endtask

    initial begin
        CE = 1'b1;
        RST_B = 1'b0;
        EPROM_BOOT_STRAP = 1'b0;
        LINK_BOOT_STRAP = 1'b0;
        BUS_OWNER = 1'b1;
        BUS_TRISTATE = 1'b0;
        HOST_WIDE = 1'b0;
        unit_v = 1'b0;
        unit_d = 16'h0000;
        bms_drv = 1'b1;
        eprom_boot();
        stream_boot(1'b0, 1'b1, 1'b0, 8, `MODE_HOST, `DMA_CH_EXT);
        stream_boot(1'b0, 1'b1, 1'b1, 16, `MODE_HOST, `DMA_CH_EXT);
        stream_boot(1'b1, 1'b1, 1'b0, 4, `MODE_LINK, `DMA_CH_LINK);
        stream_boot(1'b1, 1'b0, 1'b0, 16, `MODE_SPI, `DMA_CH_SPI);
        no_boot();
        conclude();
    end

    // Whole run is about 46000 cycles
    initial begin
        repeat (100000) @(posedge CLK_SYS);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
